// ---- verilog/emdq_regs.sv ----
// MAC DMA queue pointers, receive status and interrupt registers on AHB-Lite
// Notes on behaviour
// - RX pointer loaded by software, advances per buffer, wraps at 1024 or wrap bit.
// - TX pointer loaded by software, advances per buffer, wraps at 1024 or wrap bit.
// - TX pointer write only accepted while transmitter inactive.
// - TX pointer read gives first descriptor of current or next frame.
// - DMA moves buffer data in bursts of two words.
// - RX status flags sticky, write one clears, writes never set.
// - Buffer-missing flag set on every failed descriptor fetch.
// - Frame-received flag set when a frame is fully in memory.
// - RX overrun flag set on late grant or bus error; buffer recovered.
// - Status bit 0 on management done; all status bits clear on read.
// - Status bit 1 set when a received frame is stored.
// - Status bits 2 and 3 on RX and TX used-descriptor reads.
// - Status bit 4 on TX underrun causes or new TX pointer write.
// - Status bit 6 when TX buffers run out mid-frame.
// - Status bit 7 on each completed transmit.
// - Status bit 10 whenever RX overrun flag gets set.
// - Status bit 11 on DMA bus error response.
// - Status bit 12 on valid pause frame received.
// - Status bit 13 when pause counter decrements to zero.
// - Enable register write-only; ones unmask sources.
// - Disable register write-only; ones mask sources.
// - Read-only mask view shows masked sources at status positions.
// - Pause counter decrements once every 512 bit times.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "emdq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module emdq_regs (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // DMA and MAC events, one-cycle pulses on core_clk, with tx_active, the wrap bits and pause_time as levels
  input wire logic tx_active,
  input wire logic rx_buf_used,
  input wire logic rx_desc_wrap,
  input wire logic tx_buf_used,
  input wire logic tx_desc_wrap,
  input wire logic mgmt_done_event,
  input wire logic rx_done_event,
  input wire logic rx_owned_desc_event,
  input wire logic tx_owned_desc_event,
  input wire logic tx_underrun_event,
  input wire logic retry_limit_event,
  input wire logic tx_buffers_exhausted_event,
  input wire logic tx_done_event,
  input wire logic rx_overrun_event,
  input wire logic bus_error_event,
  input wire logic pause_received_event,
  input wire logic [15:0] pause_time,
  input wire logic bit_tick,
  // To the DMA engine
  output logic [31:0] rx_desc_addr,
  output logic [31:0] tx_desc_addr,
  output logic [1:0] dma_burst_words,
  output logic pause_active,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic emdq_pkg::emdq_word_t ptr_step(
    input emdq_pkg::emdq_word_t cur,
    input emdq_pkg::emdq_word_t base,
    input logic wrap
  );
    emdq_pkg::emdq_word_t nxt;
    nxt = cur;
    if (wrap) begin
      nxt[`EMDQ_IDX_MSB:`EMDQ_IDX_LSB] = base[`EMDQ_IDX_MSB:`EMDQ_IDX_LSB];
    end else begin
      // Index field rolls over by itself after 1024 descriptors
      nxt[`EMDQ_IDX_MSB:`EMDQ_IDX_LSB] = cur[`EMDQ_IDX_MSB:`EMDQ_IDX_LSB] + 10'h001;
    end
    return nxt;
  endfunction

  // ==========================================================
  // Bus address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;
  logic rd_take;
  logic wr_take;

  assign addr_ok = hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (clk_en) begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // Data phase write strobes and address phase status read strobe
  wire wr_rxq = wr_pend_q && (wr_addr_q == `EMDQ_OFS_RXQ);
  wire wr_txq = wr_pend_q && (wr_addr_q == `EMDQ_OFS_TXQ);
  wire wr_rxst = wr_pend_q && (wr_addr_q == `EMDQ_OFS_RXST);
  wire wr_ien = wr_pend_q && (wr_addr_q == `EMDQ_OFS_IEN);
  wire wr_idis = wr_pend_q && (wr_addr_q == `EMDQ_OFS_IDIS);
  wire rd_istat = rd_take && (haddr == `EMDQ_OFS_ISTAT);
  // Writes during an active transmit are dropped silently
  wire txq_accept = wr_txq && !tx_active;

  // ==========================================================
  // Receive queue pointer
  emdq_pkg::emdq_word_t rx_base_q;
  emdq_pkg::emdq_word_t rx_cur_q;
  emdq_pkg::emdq_word_t rx_cur_d;
  // Overrun recovers the buffer: no advance that cycle
  wire rx_adv = rx_buf_used && !rx_overrun_event;

  always_comb begin
    rx_cur_d = rx_cur_q;
    if (wr_rxq) begin
      rx_cur_d = hwdata;
    end else if (rx_adv) begin
      rx_cur_d = ptr_step(rx_cur_q, rx_base_q, rx_desc_wrap);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_base_q <= `EMDQ_PTR_RST;
      rx_cur_q <= `EMDQ_PTR_RST;
    end else if (clk_en) begin
      rx_cur_q <= rx_cur_d;
      if (wr_rxq) begin
        rx_base_q <= hwdata;
      end
    end
  end

  // ==========================================================
  // Transmit queue pointer
  emdq_pkg::emdq_word_t tx_base_q;
  emdq_pkg::emdq_word_t tx_cur_q;
  emdq_pkg::emdq_word_t tx_cur_d;
  emdq_pkg::emdq_word_t tx_frame_q;
  emdq_pkg::emdq_word_t tx_frame_d;

  always_comb begin
    tx_cur_d = tx_cur_q;
    tx_frame_d = tx_frame_q;
    if (txq_accept) begin
      tx_cur_d = hwdata;
      tx_frame_d = hwdata;
    end else begin
      if (tx_buf_used) begin
        tx_cur_d = ptr_step(tx_cur_q, tx_base_q, tx_desc_wrap);
      end
      // Frame boundary: the next frame starts where the pointer now stands
      if (tx_done_event) begin
        tx_frame_d = tx_cur_d;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_base_q <= `EMDQ_PTR_RST;
      tx_cur_q <= `EMDQ_PTR_RST;
      tx_frame_q <= `EMDQ_PTR_RST;
    end else if (clk_en) begin
      tx_cur_q <= tx_cur_d;
      tx_frame_q <= tx_frame_d;
      if (txq_accept) begin
        tx_base_q <= hwdata;
      end
    end
  end

  assign rx_desc_addr = rx_cur_q;
  assign tx_desc_addr = tx_cur_q;
  // Bit 2 is not forced low; an odd pointer may still cross 1K
  assign dma_burst_words = `EMDQ_BURST_WORDS;

  // ==========================================================
  // Receive status flags
  emdq_pkg::emdq_rxst_t rxst_q;
  emdq_pkg::emdq_rxst_t rxst_set;
  emdq_pkg::emdq_rxst_t rxst_clr;

  assign rxst_set[`EMDQ_RX_MISSING] = rx_owned_desc_event;
  assign rxst_set[`EMDQ_RX_FRAME] = rx_done_event;
  assign rxst_set[`EMDQ_RX_OVERRUN] = rx_overrun_event;
  assign rxst_clr = wr_rxst ? hwdata[`EMDQ_RXST_W-1:0] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rxst_q <= 3'h0;
    end else if (clk_en) begin
      // Set wins over a simultaneous clear
      rxst_q <= (rxst_q & ~rxst_clr) | rxst_set;
    end
  end

  // ==========================================================
  // Pause counter
  logic [15:0] pause_q;
  logic [`EMDQ_QCNT_W-1:0] quantum_q;
  logic pause_zero_q;
  wire quantum_end = bit_tick && (quantum_q == 9'(`EMDQ_PAUSE_QUANTUM_BITS - 1));
  wire pause_dec = quantum_end && (pause_q != 16'h0000);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pause_q <= 16'h0000;
      quantum_q <= 9'h000;
      pause_zero_q <= 1'b0;
    end else if (clk_en) begin
      pause_zero_q <= pause_dec && (pause_q == 16'h0001);
      if (pause_received_event) begin
        pause_q <= pause_time;
        quantum_q <= 9'h000;
      end else begin
        if (bit_tick && (pause_q != 16'h0000)) begin
          quantum_q <= quantum_q + 9'h001;
        end
        if (pause_dec) begin
          pause_q <= pause_q - 16'h0001;
        end
      end
    end
  end

  assign pause_active = (pause_q != 16'h0000);

  // ==========================================================
  // Interrupt status, mask and output
  emdq_pkg::emdq_irq_t isr_q;
  emdq_pkg::emdq_irq_t imr_q;
  emdq_pkg::emdq_irq_t isr_set;
  emdq_pkg::emdq_irq_t isr_clr;
  emdq_pkg::emdq_irq_t ien_bits;
  emdq_pkg::emdq_irq_t idis_bits;

  always_comb begin
    isr_set = 14'h0000;
    isr_set[`EMDQ_I_MGMT] = mgmt_done_event;
    isr_set[`EMDQ_I_RXDONE] = rx_done_event;
    isr_set[`EMDQ_I_RXOWN] = rx_owned_desc_event;
    isr_set[`EMDQ_I_TXOWN] = tx_owned_desc_event;
    isr_set[`EMDQ_I_TXUND] = tx_underrun_event || txq_accept;
    isr_set[`EMDQ_I_RETRY] = retry_limit_event;
    isr_set[`EMDQ_I_TXEXH] = tx_buffers_exhausted_event;
    isr_set[`EMDQ_I_TXDONE] = tx_done_event;
    isr_set[`EMDQ_I_RXOVR] = rx_overrun_event;
    isr_set[`EMDQ_I_BUSERR] = bus_error_event;
    isr_set[`EMDQ_I_PAUSE] = pause_received_event;
    isr_set[`EMDQ_I_PZERO] = pause_zero_q;
  end

  assign isr_clr = rd_istat ? 14'h3FFF : 14'h0000;
  assign ien_bits = wr_ien ? (hwdata[`EMDQ_IRQ_W-1:0] & `EMDQ_IRQ_IMPL) : 14'h0000;
  assign idis_bits = wr_idis ? (hwdata[`EMDQ_IRQ_W-1:0] & `EMDQ_IRQ_IMPL) : 14'h0000;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      isr_q <= 14'h0000;
      imr_q <= `EMDQ_MASK_RST;
    end else if (clk_en) begin
      isr_q <= (isr_q & ~isr_clr) | isr_set;
      // Zero bits leave the mask alone; disable beats enable
      imr_q <= (imr_q & ~ien_bits) | idis_bits;
    end
  end

  logic irq_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(isr_q & ~imr_q);
    end
  end
  assign irq = irq_q;

  // ==========================================================
  // Read data, registered at the address phase
  emdq_pkg::emdq_word_t rd_mux;
  assign rd_mux =
    (haddr == `EMDQ_OFS_RXQ) ? rx_cur_q :
    (haddr == `EMDQ_OFS_TXQ) ? tx_frame_q :
    (haddr == `EMDQ_OFS_RXST) ? {29'h0, rxst_q} :
    (haddr == `EMDQ_OFS_ISTAT) ? {18'h0, isr_q} :
    (haddr == `EMDQ_OFS_IMASK) ? {18'h0, imr_q} :
    32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && rd_take) begin
      hrdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ---- include/emdq_defs.svh ----
// Offsets, field positions, reset values and timing counts for the MAC queue block
`ifndef EMDQ_DEFS_SVH
`define EMDQ_DEFS_SVH

// ==========================================================
// Register byte offsets
`define EMDQ_OFS_RXQ 8'h00
`define EMDQ_OFS_TXQ 8'h04
`define EMDQ_OFS_RXST 8'h08
`define EMDQ_OFS_ISTAT 8'h0C
`define EMDQ_OFS_IEN 8'h10
`define EMDQ_OFS_IDIS 8'h14
`define EMDQ_OFS_IMASK 8'h18

// ==========================================================
// Receive status flag positions
`define EMDQ_RX_MISSING 0
`define EMDQ_RX_FRAME 1
`define EMDQ_RX_OVERRUN 2
`define EMDQ_RXST_W 3

// ==========================================================
// Interrupt status bit positions
`define EMDQ_I_MGMT 0
`define EMDQ_I_RXDONE 1
`define EMDQ_I_RXOWN 2
`define EMDQ_I_TXOWN 3
`define EMDQ_I_TXUND 4
`define EMDQ_I_RETRY 5
`define EMDQ_I_TXEXH 6
`define EMDQ_I_TXDONE 7
`define EMDQ_I_RXOVR 10
`define EMDQ_I_BUSERR 11
`define EMDQ_I_PAUSE 12
`define EMDQ_I_PZERO 13
`define EMDQ_IRQ_W 14
`define EMDQ_IRQ_IMPL 14'h3CFF

// ==========================================================
// Reset values and queue geometry
`define EMDQ_PTR_RST 32'h0000_0000
`define EMDQ_MASK_RST 14'h3CFF
`define EMDQ_IDX_LSB 3
`define EMDQ_IDX_MSB 12
`define EMDQ_BURST_WORDS 2'h2

// ==========================================================
// Pause timing
`define EMDQ_PAUSE_QUANTUM_BITS 512
`define EMDQ_QCNT_W 9

`endif

// ---- include/emdq_pkg.sv ----
// Types shared by the MAC queue and interrupt register block
package emdq_pkg;
  typedef logic [31:0] emdq_word_t;
  typedef logic [13:0] emdq_irq_t;
  typedef logic [2:0] emdq_rxst_t;
endpackage

// ---- bench/emdq_regs_monitor.sv ----
// Concurrent checks on the queue and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "emdq_defs.svh"
module emdq_regs_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic tx_active,
  input wire logic rx_buf_used,
  input wire logic rx_desc_wrap,
  input wire logic tx_buf_used,
  input wire logic tx_desc_wrap,
  input wire logic rx_overrun_event,
  input wire logic pause_received_event,
  input wire logic [15:0] pause_time,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [31:0] tx_desc_addr,
  input wire logic [1:0] dma_burst_words,
  input wire logic pause_active,
  input wire logic irq
);
  wire logic wr = clk_en && hsel && hready && htrans[1] && hwrite;
  wire logic wr_rx = wr && haddr == `EMDQ_OFS_RXQ;
  wire logic wr_tx = wr && haddr == `EMDQ_OFS_TXQ;
  wire logic wr_ds = wr && haddr == `EMDQ_OFS_IDIS;
  wire logic rd_st = clk_en && hsel && hready && htrans[1] && !hwrite && haddr == `EMDQ_OFS_ISTAT;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Queue pointers
  AST_RX_STEP: assert property (
    rx_buf_used && !rx_desc_wrap && !rx_overrun_event && !$past(wr_rx)
    |=> rx_desc_addr[12:3] == 10'($past(rx_desc_addr[12:3]) + 10'h1)) else $error("rx step");
  AST_RX_HOLD: assert property (
    !rx_buf_used && !$past(wr_rx) |=> $stable(rx_desc_addr)) else $error("rx pointer moved");
  AST_TX_STEP: assert property (
    tx_buf_used && !tx_desc_wrap && !$past(wr_tx)
    |=> tx_desc_addr[12:3] == 10'($past(tx_desc_addr[12:3]) + 10'h1)) else $error("tx step");
  AST_TX_LOCK: assert property (
    wr_tx && tx_active ##1 tx_active |=> $stable(tx_desc_addr[31:13])) else $error("tx lock");
  AST_BURST: assert property (
    dma_burst_words == `EMDQ_BURST_WORDS) else $error("burst length wrong");
  // ==========================================================
  // Pause and interrupt line
  AST_PAUSE: assert property (
    pause_received_event && pause_time != 16'h0 |=> pause_active) else $error("pause idle");
  AST_IRQ_RST: assert property (
    $rose(reset_n) |-> !irq) else $error("irq after reset");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(rd_st, 2) || $past(wr_ds, 3)) else $error("irq dropped alone");
endmodule
bind emdq_regs emdq_regs_monitor i_mon (.core_clk, .reset_n, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .tx_active, .rx_buf_used, .rx_desc_wrap, .tx_buf_used, .tx_desc_wrap,
  .rx_overrun_event, .pause_received_event, .pause_time, .rx_desc_addr, .tx_desc_addr,
  .dma_burst_words, .pause_active, .irq);
`default_nettype wire

// ---- bench/emdq_dma_model.sv ----
// Far-side DMA engine model: turns requests into event pulses one cycle later
`timescale 1ns/1ps
`default_nettype none
module emdq_dma_model (
  input wire logic core_clk,
  input wire logic [12:0] go,
  output logic [12:0] ev_q
);
  // Registered so every pulse is clean and lasts as long as go is held
  always_ff @(posedge core_clk) begin
    ev_q <= go;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the queue and interrupt register block
`timescale 1ns/1ps
`default_nettype none
`include "emdq_defs.svh"
module tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic tx_active = 1'b0;
  logic clk_en = 1'b1;
  logic wrap = 1'b0;
  logic bit_tick = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [12:0] go = 13'h0000;
  logic [15:0] ptime = 16'h0000;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'h60BA;
  logic [31:0] v;
  logic [31:0] expq[$];
  int mismatches = 0;
  int samples_checked = 0;
  wire logic hreadyout;
  wire logic irq;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [12:0] ev;
  always #4 core_clk = ~core_clk;
  emdq_dma_model i_mem (.core_clk(core_clk), .go(go), .ev_q(ev));
  emdq_regs i_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_active(tx_active), .rx_buf_used(ev[11]), .rx_desc_wrap(wrap), .tx_buf_used(ev[12]),
    .tx_desc_wrap(wrap), .mgmt_done_event(ev[0]), .rx_done_event(ev[1]),
    .rx_owned_desc_event(ev[2]), .tx_owned_desc_event(ev[3]), .tx_underrun_event(ev[4]),
    .retry_limit_event(ev[5]), .tx_buffers_exhausted_event(ev[6]), .tx_done_event(ev[7]),
    .rx_overrun_event(ev[8]), .bus_error_event(ev[9]), .pause_received_event(ev[10]),
    .pause_time(ptime), .bit_tick(bit_tick), .rx_desc_addr(), .tx_desc_addr(),
    .dma_burst_words(), .pause_active(), .irq(irq));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'hFFFF_FFFB;
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] p);
    nx = p;
    nx[12:3] = p[12:3] + 10'h1;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic pulse(input logic [12:0] g);
    go <= g;
    @(posedge core_clk);
    go <= 13'h0000;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Read data answers one cycle after the address phase
  always @(posedge core_clk) begin
    if (rd_dp) chk("hrdata", hrdata, expq.pop_front());
    if (rd_dp) chk("hresp", {31'h0, hresp}, 32'h0);
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    #60000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(`EMDQ_OFS_RXQ, `EMDQ_PTR_RST);
    rd(`EMDQ_OFS_IMASK, 32'h3CFF);
    rd(8'h1C, 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = xs();
      if (i == 1) v[12:3] = 10'h3FF;
      bus(`EMDQ_OFS_RXQ, 1'b1, v);
      wrap <= (i == 2);
      pulse(13'h0800);
      rd(`EMDQ_OFS_RXQ, (i == 2) ? v : nx(v));
    end
    wrap <= 1'b0;
    // Overrun with a consumed buffer: the buffer is recovered, no advance
    pulse(13'h0900);
    rd(`EMDQ_OFS_RXQ, v);
    rd(`EMDQ_OFS_ISTAT, 32'h400);
    tx_active <= 1'b1;
    bus(`EMDQ_OFS_TXQ, 1'b1, 32'h0012_3450);
    tx_active <= 1'b0;
    rd(`EMDQ_OFS_TXQ, 32'h0);
    v = xs();
    bus(`EMDQ_OFS_TXQ, 1'b1, v);
    rd(`EMDQ_OFS_ISTAT, 32'h10);
    pulse(13'h1000);
    rd(`EMDQ_OFS_TXQ, v);
    pulse(13'h0080);
    rd(`EMDQ_OFS_TXQ, nx(v));
    rd(`EMDQ_OFS_ISTAT, 32'h80);
    for (int k = 0; k < 11; k++) begin
      pulse(13'(1 << k));
      rd(`EMDQ_OFS_ISTAT, 32'h1 << (k < 8 ? k : k + 2));
      rd(`EMDQ_OFS_ISTAT, 32'h0);
    end
    rd(`EMDQ_OFS_RXST, 32'h7);
    bus(`EMDQ_OFS_RXST, 1'b1, 32'h2);
    bus(`EMDQ_OFS_RXST, 1'b1, 32'h0);
    rd(`EMDQ_OFS_RXST, 32'h5);
    pulse(13'h0080);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(`EMDQ_OFS_IEN, 1'b1, 32'h80);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(`EMDQ_OFS_IDIS, 1'b1, 32'h0);
    rd(`EMDQ_OFS_IMASK, 32'h3C7F);
    rd(`EMDQ_OFS_ISTAT, 32'h80);
    @(posedge core_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(`EMDQ_OFS_IDIS, 1'b1, 32'h80);
    rd(`EMDQ_OFS_IMASK, 32'h3CFF);
    ptime <= 16'h0001;
    pulse(13'h0400);
    bit_tick <= 1'b1;
    repeat (`EMDQ_PAUSE_QUANTUM_BITS - 20) @(posedge core_clk);
    rd(`EMDQ_OFS_ISTAT, 32'h1000);
    repeat (30) @(posedge core_clk);
    rd(`EMDQ_OFS_ISTAT, 32'h2000);
    bit_tick <= 1'b0;
    // Frozen clock enable: an event pulse must leave no trace
    clk_en <= 1'b0;
    pulse(13'h0001);
    clk_en <= 1'b1;
    rd(`EMDQ_OFS_ISTAT, 32'h0);
    repeat (3) @(posedge core_clk);
    close_out();
  end
endmodule
`default_nettype wire
